// File: hw/pll_ratio_strap_config.sv
// Contract
// - Platform clock is reference clock times ratio from four-bit strap.
// - Platform strap decodes to 16,2,3,4,5,6,8,9,10,12,20; five codes reserved.
// - Core ratio from three strap bits: 4,9/2,rsv,3/2,2,5/2,3,7/2.
// - Platform clock and platform bus clock are the same clock.
// - Memory bus clock runs at half the platform clock.
// - Core clock is derived from platform clock, not reference.
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`include "pll_ratio_map.svh"

module pll_ratio_strap_config
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] platformRatioStrap,
    input wire logic coreRatioStrapBit2,
    input wire logic coreRatioStrapBit1,
    input wire logic coreRatioStrapBit0,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [4:0] platformMult,
    output logic [3:0] coreHalfRatio,
    output logic ratioLocked,
    output logic ratioFault
);

    // ======================================================================
    // helpers
    // ======================================================================
    function automatic pll_ratio_pkg::regSel_t decodeReg(input logic [7:0] addr);
        pll_ratio_pkg::regSel_t sel;
        sel = pll_ratio_pkg::SEL_NONE;
        unique case (addr)
            `REG_STRAP_CODES: sel = pll_ratio_pkg::SEL_STRAP;
            `REG_RATIOS: sel = pll_ratio_pkg::SEL_RATIOS;
            `REG_REF_KHZ: sel = pll_ratio_pkg::SEL_REF;
            `REG_PLAT_KHZ: sel = pll_ratio_pkg::SEL_PLAT;
            `REG_CORE_KHZ: sel = pll_ratio_pkg::SEL_CORE;
            `REG_MEM_KHZ: sel = pll_ratio_pkg::SEL_MEM;
            `REG_LIMIT_CFG: sel = pll_ratio_pkg::SEL_LIMIT;
            `REG_RANGE_FLAGS: sel = pll_ratio_pkg::SEL_FLAGS;
            default: sel = pll_ratio_pkg::SEL_NONE;
        endcase
        return sel;
    endfunction

    function automatic logic [31:0] mergeStrb(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = oldVal;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ======================================================================
    // state
    // ======================================================================
    pll_ratio_pkg::cfgState_t stQ;
    pll_ratio_pkg::cfgState_t stD;

    logic [2:0] coreStrap;
    logic [4:0] liveMult;
    logic liveRsvPlat;
    logic [3:0] liveHalves;
    logic liveRsvCore;
    logic [31:0] calcPlat;
    logic [31:0] calcCore;
    logic [31:0] calcMem;

    assign coreStrap = {coreRatioStrapBit2, coreRatioStrapBit1, coreRatioStrapBit0};

    // ======================================================================
    // submodules
    // ======================================================================
    strap_ratio_decode u_decode
    (
        .platCode(platformRatioStrap),
        .coreCode(coreStrap),
        .platMult(liveMult),
        .platRsv(liveRsvPlat),
        .coreHalves(liveHalves),
        .coreRsv(liveRsvCore)
    );

    freq_calc u_calc
    (
        .refKhz(stQ.refKhz),
        .platMult(stQ.platMult),
        .coreHalves(stQ.coreHalves),
        .platKhz(calcPlat),
        .coreKhz(calcCore),
        .memKhz(calcMem)
    );

    // ======================================================================
    // next state
    // ======================================================================
    logic [31:0] coreMax;
    logic [31:0] memMax;
    logic [31:0] merged;
    logic [31:0] readVal;
    logic readOk;
    pll_ratio_pkg::regSel_t wSel;
    pll_ratio_pkg::regSel_t rSel;

    always_comb
    begin
        stD = stQ;
        merged = 32'h00000000;
        readVal = 32'h00000000;
        readOk = 1'b1;
        wSel = decodeReg(stQ.awAddr);
        rSel = decodeReg(s_axi_araddr);

        // strap capture: once only, pins are shared with other uses later
        unique case (stQ.state)
            pll_ratio_pkg::ST_RESET:
            begin
                stD.state = pll_ratio_pkg::ST_SAMPLE;
            end
            pll_ratio_pkg::ST_SAMPLE:
            begin
                stD.platCode = platformRatioStrap;
                stD.coreCode = coreStrap;
                stD.platMult = liveMult;
                stD.platRsv = liveRsvPlat;
                stD.coreHalves = liveHalves;
                stD.coreRsv = liveRsvCore;
                stD.state = pll_ratio_pkg::ST_LOCKED;
            end
            pll_ratio_pkg::ST_LOCKED:
            begin
                stD.state = pll_ratio_pkg::ST_LOCKED;
            end
            default:
            begin
                stD.state = pll_ratio_pkg::ST_RESET;
            end
        endcase

        // frequency figures and range monitor
        stD.platKhz = calcPlat;
        stD.coreKhz = calcCore;
        stD.memKhz = calcMem;
        unique case (stQ.gradeSel)
            2'h0: coreMax = `CORE_MAX1_KHZ;
            2'h1: coreMax = `CORE_MAX2_KHZ;
            default: coreMax = `CORE_MAX3_KHZ;
        endcase
        memMax = stQ.smallVariant ? `MEM_MAX_SMALL_KHZ : `MEM_MAX_LARGE_KHZ;
        stD.rangeFlags[`FLAG_PLAT_LOW] = stQ.platKhz < `PLAT_MIN_KHZ;
        stD.rangeFlags[`FLAG_CORE_LOW] = stQ.coreKhz < `CORE_MIN_KHZ;
        stD.rangeFlags[`FLAG_CORE_HIGH] = stQ.coreKhz > coreMax;
        stD.rangeFlags[`FLAG_MEM_LOW] = stQ.memKhz < `MEM_MIN_KHZ;
        stD.rangeFlags[`FLAG_MEM_HIGH] = stQ.memKhz > memMax;
        stD.rangeFlags[`FLAG_REF_ERRATA] = ({14'h0000, stQ.refKhz} > `REF_ERRATA_KHZ)
            && (stQ.coreKhz < `CORE_ERRATA_KHZ);
        stD.rangeFlags[`FLAG_PLAT_RSV] = stQ.platRsv;
        stD.rangeFlags[`FLAG_CORE_RSV] = stQ.coreRsv;
        stD.fault = |stD.rangeFlags;

        // write address and data are taken independently
        if (s_axi_awvalid && stQ.awready)
        begin
            stD.awHeld = 1'b1;
            stD.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && stQ.wready)
        begin
            stD.wHeld = 1'b1;
            stD.wData = s_axi_wdata;
            stD.wStrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            stD.bvalid = 1'b0;
        end
        if (stQ.awHeld && stQ.wHeld && !stQ.bvalid)
        begin
            stD.awHeld = 1'b0;
            stD.wHeld = 1'b0;
            stD.bvalid = 1'b1;
            stD.bresp = `RESP_OKAY;
            unique case (wSel)
                pll_ratio_pkg::SEL_REF:
                begin
                    merged = mergeStrb({14'h0000, stQ.refKhz}, stQ.wData, stQ.wStrb);
                    stD.refKhz = merged[17:0];
                end
                pll_ratio_pkg::SEL_LIMIT:
                begin
                    merged = mergeStrb({29'h00000000, stQ.smallVariant, stQ.gradeSel},
                        stQ.wData, stQ.wStrb);
                    stD.gradeSel = merged[`LIMIT_GRADE_LSB +: 2];
                    stD.smallVariant = merged[`LIMIT_SMALL_BIT];
                end
                pll_ratio_pkg::SEL_NONE:
                begin
                    stD.bresp = `RESP_SLVERR;
                end
                default:
                begin
                    // read-only register: write dropped, still answered okay
                    stD.bresp = `RESP_OKAY;
                end
            endcase
        end
        stD.awready = !stD.awHeld && !stD.bvalid;
        stD.wready = !stD.wHeld && !stD.bvalid;

        // read: one outstanding, answered the cycle after acceptance
        unique case (rSel)
            pll_ratio_pkg::SEL_STRAP:
            begin
                readVal[`STRAP_PLAT_LSB +: 4] = stQ.platCode;
                readVal[`STRAP_CORE_LSB +: 3] = stQ.coreCode;
                readVal[`STRAP_LOCK_BIT] = stQ.state == pll_ratio_pkg::ST_LOCKED;
            end
            pll_ratio_pkg::SEL_RATIOS:
            begin
                readVal[`RATIO_PLAT_LSB +: 5] = stQ.platMult;
                readVal[`RATIO_CORE_LSB +: 4] = stQ.coreHalves;
            end
            pll_ratio_pkg::SEL_REF: readVal = {14'h0000, stQ.refKhz};
            pll_ratio_pkg::SEL_PLAT: readVal = stQ.platKhz;
            pll_ratio_pkg::SEL_CORE: readVal = stQ.coreKhz;
            pll_ratio_pkg::SEL_MEM: readVal = stQ.memKhz;
            pll_ratio_pkg::SEL_LIMIT:
            begin
                readVal[`LIMIT_GRADE_LSB +: 2] = stQ.gradeSel;
                readVal[`LIMIT_SMALL_BIT] = stQ.smallVariant;
            end
            pll_ratio_pkg::SEL_FLAGS: readVal = {24'h000000, stQ.rangeFlags};
            default: readOk = 1'b0;
        endcase
        if (s_axi_rvalid && s_axi_rready)
        begin
            stD.rvalid = 1'b0;
        end
        if (s_axi_arvalid && stQ.arready)
        begin
            stD.rvalid = 1'b1;
            stD.rdata = readVal;
            stD.rresp = readOk ? `RESP_OKAY : `RESP_SLVERR;
        end
        stD.arready = !stD.rvalid;
    end

    // ======================================================================
    // registers
    // ======================================================================
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stQ <= '0;
            stQ.state <= pll_ratio_pkg::ST_RESET;
            stQ.refKhz <= `REF_KHZ_RESET;
            stQ.gradeSel <= `GRADE_RESET;
            stQ.smallVariant <= `SMALL_RESET;
            stQ.bresp <= `RESP_OKAY;
            stQ.rresp <= `RESP_OKAY;
        end
        else
        begin
            stQ <= stD;
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================
    assign s_axi_awready = stQ.awready;
    assign s_axi_wready = stQ.wready;
    assign s_axi_bvalid = stQ.bvalid;
    assign s_axi_bresp = stQ.bresp;
    assign s_axi_arready = stQ.arready;
    assign s_axi_rvalid = stQ.rvalid;
    assign s_axi_rdata = stQ.rdata;
    assign s_axi_rresp = stQ.rresp;
    assign platformMult = stQ.platMult;
    assign coreHalfRatio = stQ.coreHalves;
    assign ratioLocked = stQ.state[2];
    assign ratioFault = stQ.fault;

endmodule

// File: shared/pll_ratio_map.svh
`ifndef PLL_RATIO_MAP_SVH
`define PLL_RATIO_MAP_SVH

// ==========================================================================
// register offsets (byte addresses)
// ==========================================================================
`define REG_STRAP_CODES 8'h00
`define REG_RATIOS 8'h04
`define REG_REF_KHZ 8'h08
`define REG_PLAT_KHZ 8'h0C
`define REG_CORE_KHZ 8'h10
`define REG_MEM_KHZ 8'h14
`define REG_LIMIT_CFG 8'h18
`define REG_RANGE_FLAGS 8'h1C

// ==========================================================================
// field positions
// ==========================================================================
`define STRAP_PLAT_LSB 0
`define STRAP_CORE_LSB 4
`define STRAP_LOCK_BIT 8
`define RATIO_PLAT_LSB 0
`define RATIO_CORE_LSB 8
`define LIMIT_GRADE_LSB 0
`define LIMIT_SMALL_BIT 2
`define FLAG_PLAT_LOW 0
`define FLAG_CORE_LOW 1
`define FLAG_CORE_HIGH 2
`define FLAG_MEM_LOW 3
`define FLAG_MEM_HIGH 4
`define FLAG_REF_ERRATA 5
`define FLAG_PLAT_RSV 6
`define FLAG_CORE_RSV 7

// ==========================================================================
// reset values
// ==========================================================================
`define REF_KHZ_RESET 18'h186A0
`define GRADE_RESET 2'h0
`define SMALL_RESET 1'h0

// ==========================================================================
// frequency limits in kHz
// ==========================================================================
`define PLAT_MIN_KHZ 32'h000514C8
`define CORE_MIN_KHZ 32'h000C3500
`define CORE_MAX1_KHZ 32'h000F4240
`define CORE_MAX2_KHZ 32'h00124F80
`define CORE_MAX3_KHZ 32'h00145708
`define MEM_MIN_KHZ 32'h00028870
`define MEM_MAX_LARGE_KHZ 32'h00040F10
`define MEM_MAX_SMALL_KHZ 32'h00030D40
`define REF_ERRATA_KHZ 32'h000186A0
`define CORE_ERRATA_KHZ 32'h00124F80

// ==========================================================================
// bus responses
// ==========================================================================
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: shared/pll_ratio_pkg.sv
package pll_ratio_pkg;

    typedef enum logic [2:0]
    {
        ST_RESET = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_LOCKED = 3'b100
    } strapState_t;

    typedef enum logic [3:0]
    {
        SEL_STRAP, SEL_RATIOS, SEL_REF, SEL_PLAT, SEL_CORE, SEL_MEM,
        SEL_LIMIT, SEL_FLAGS, SEL_NONE
    } regSel_t;

    typedef struct packed {
        strapState_t state;
        logic [3:0] platCode;
        logic [2:0] coreCode;
        logic [4:0] platMult;
        logic [3:0] coreHalves;
        logic platRsv;
        logic coreRsv;
        logic [17:0] refKhz;
        logic [1:0] gradeSel;
        logic smallVariant;
        logic [31:0] platKhz;
        logic [31:0] coreKhz;
        logic [31:0] memKhz;
        logic [7:0] rangeFlags;
        logic fault;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cfgState_t;

endpackage

// File: hw/strap_ratio_decode.sv
// ==========================================================================
// strap code to ratio tables
// ==========================================================================
module strap_ratio_decode
(
    input wire logic [3:0] platCode,
    input wire logic [2:0] coreCode,
    output logic [4:0] platMult,
    output logic platRsv,
    output logic [3:0] coreHalves,
    output logic coreRsv
);

    // reserved codes give a zero multiplier so no frequency is reported
    always_comb
    begin
        platRsv = 1'b0;
        unique case (platCode)
            4'h0: platMult = 5'h10;
            4'h2: platMult = 5'h02;
            4'h3: platMult = 5'h03;
            4'h4: platMult = 5'h04;
            4'h5: platMult = 5'h05;
            4'h6: platMult = 5'h06;
            4'h8: platMult = 5'h08;
            4'h9: platMult = 5'h09;
            4'hA: platMult = 5'h0A;
            4'hC: platMult = 5'h0C;
            4'hD: platMult = 5'h14;
            default:
            begin
                platMult = 5'h00;
                platRsv = 1'b1;
            end
        endcase
    end

    // core ratio held in halves: 4:1 is 8, 9:2 is 9
    always_comb
    begin
        coreRsv = 1'b0;
        unique case (coreCode)
            3'h0: coreHalves = 4'h8;
            3'h1: coreHalves = 4'h9;
            3'h2:
            begin
                coreHalves = 4'h0;
                coreRsv = 1'b1;
            end
            3'h3: coreHalves = 4'h3;
            3'h4: coreHalves = 4'h4;
            3'h5: coreHalves = 4'h5;
            3'h6: coreHalves = 4'h6;
            3'h7: coreHalves = 4'h7;
        endcase
    end

endmodule

// File: hw/freq_calc.sv
// ==========================================================================
// derived frequencies in kHz
// ==========================================================================
module freq_calc
(
    input wire logic [17:0] refKhz,
    input wire logic [4:0] platMult,
    input wire logic [3:0] coreHalves,
    output logic [31:0] platKhz,
    output logic [31:0] coreKhz,
    output logic [31:0] memKhz
);

    logic [22:0] platProd;
    logic [26:0] coreProd;

    assign platProd = refKhz * platMult;
    // core follows the platform figure, never the reference directly
    assign coreProd = platProd * coreHalves;
    assign platKhz = {9'h000, platProd};
    assign coreKhz = {6'h00, coreProd[26:1]};
    assign memKhz = {10'h000, platProd[22:1]};

endmodule

// File: test/pll_ratio_properties.sv
// ==========================================================================
// port-level checks of strap capture and register bus handshakes
// ==========================================================================
module pll_ratio_properties
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] platformRatioStrap,
    input wire logic coreRatioStrapBit2,
    input wire logic coreRatioStrapBit1,
    input wire logic coreRatioStrapBit0,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [4:0] platformMult,
    input wire logic [3:0] coreHalfRatio,
    input wire logic ratioLocked,
    input wire logic ratioFault
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] PLAT_TAB [16] = '{5'h10, 5'h00, 5'h02, 5'h03, 5'h04, 5'h05,
        5'h06, 5'h00, 5'h08, 5'h09, 5'h0A, 5'h00, 5'h0C, 5'h14, 5'h00, 5'h00};
    localparam logic [3:0] CORE_TAB [8] = '{4'h8, 4'h9, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_lock_second_edge: assert property (
        $fell(sys_rst) |-> !ratioLocked ##1 !ratioLocked ##1 ratioLocked)
        else $error("lock timing");
    a_ratio_held: assert property (
        ratioLocked |=> ratioLocked && $stable(platformMult) && $stable(coreHalfRatio))
        else $error("ratios moved after lock");
    a_plat_decode: assert property (
        $rose(ratioLocked) |-> platformMult == PLAT_TAB[$past(platformRatioStrap)])
        else $error("platform ratio decode");
    a_core_decode: assert property (
        $rose(ratioLocked) |-> coreHalfRatio == CORE_TAB[$past({coreRatioStrapBit2,
        coreRatioStrapBit1, coreRatioStrapBit0})])
        else $error("core ratio decode");
    a_reserved_fault: assert property (
        $rose(ratioLocked) && (platformMult == 5'h00 || coreHalfRatio == 4'h0)
        |-> ##2 ratioFault)
        else $error("reserved code without fault");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write response timing");
    a_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response timing");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
endmodule

// File: test/strap_board_model.sv
// ==========================================================================
// board pull resistors on the strap pins
// ==========================================================================
module strap_board_model
(
    input wire logic [3:0] platCode,
    input wire logic [2:0] coreCode,
    input wire logic scramble,
    output logic [3:0] platformRatioStrap,
    output logic coreRatioStrapBit2,
    output logic coreRatioStrapBit1,
    output logic coreRatioStrapBit0
);
    timeunit 1ns;
    timeprecision 1ps;
    // scramble models the shared pins reused as bus lines after power-up
    assign platformRatioStrap = scramble ? ~platCode : platCode;
    assign {coreRatioStrapBit2, coreRatioStrapBit1, coreRatioStrapBit0} =
        scramble ? ~coreCode : coreCode;
endmodule

// File: test/testbench.sv
`include "pll_ratio_map.svh"

`define CHECK(name, got, exp) \
    begin \
        nChecks++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got); \
        end \
    end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] PLAT_TAB [16] = '{5'h10, 5'h00, 5'h02, 5'h03, 5'h04, 5'h05,
        5'h06, 5'h00, 5'h08, 5'h09, 5'h0A, 5'h00, 5'h0C, 5'h14, 5'h00, 5'h00};
    localparam logic [3:0] CORE_TAB [8] = '{4'h8, 4'h9, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    logic ref_clk, sys_rst, scramble, ratioLocked, ratioFault;
    logic [3:0] platSel, platformRatioStrap, s_axi_wstrb, h, coreHalfRatio;
    logic [2:0] coreSel;
    logic coreRatioStrapBit2, coreRatioStrapBit1, coreRatioStrapBit0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, p;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [4:0] platformMult, m;
    int fails = 0;
    int nChecks = 0;

    strap_board_model board (.platCode(platSel), .coreCode(coreSel), .scramble(scramble),
        .platformRatioStrap(platformRatioStrap), .coreRatioStrapBit2(coreRatioStrapBit2),
        .coreRatioStrapBit1(coreRatioStrapBit1), .coreRatioStrapBit0(coreRatioStrapBit0));

    pll_ratio_strap_config dut (.ref_clk, .sys_rst, .platformRatioStrap, .coreRatioStrapBit2,
        .coreRatioStrapBit1, .coreRatioStrapBit0, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .platformMult, .coreHalfRatio, .ratioLocked, .ratioFault);

    always #10 ref_clk = ~ref_clk;

    // ======================================================================
    // expected range flags, all limits strict
    // ======================================================================
    function automatic logic [7:0] expFlags(logic [31:0] r, logic [4:0] mu, logic [3:0] hv,
        logic [1:0] g, logic s);
        logic [31:0] pl, co, mx;
        pl = r * mu;
        co = pl * hv / 2;
        mx = (g == 2'h0) ? `CORE_MAX1_KHZ : (g == 2'h1) ? `CORE_MAX2_KHZ : `CORE_MAX3_KHZ;
        return {hv == 4'h0, mu == 5'h00, r > `REF_ERRATA_KHZ && co < `CORE_ERRATA_KHZ,
            pl / 2 > (s ? `MEM_MAX_SMALL_KHZ : `MEM_MAX_LARGE_KHZ), pl / 2 < `MEM_MIN_KHZ,
            co > mx, co < `CORE_MIN_KHZ, pl < `PLAT_MIN_KHZ};
    endfunction

    // ======================================================================
    // bus master tasks; ready stands from the request on
    // ======================================================================
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever
        begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid)
                break;
        end
        s_axi_bready <= 1'h0;
        `CHECK("bresp", s_axi_bresp, resp)
    endtask

    task automatic axiRead(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever
        begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid)
                break;
        end
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic checkReg(input logic [7:0] a, input logic [31:0] exp, input string name);
        axiRead(a);
        `CHECK(name, rd, exp)
        `CHECK("rresp", rr, `RESP_OKAY)
    endtask

    task automatic powerUp(input logic [3:0] pc, input logic [2:0] cc);
        sys_rst <= 1'h1;
        platSel <= pc;
        coreSel <= cc;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'h0;
        // locked at edge 2, flags settled at edge 4
        repeat (5) @(posedge ref_clk);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ======================================================================
    // scenarios
    // ======================================================================
    initial
    begin
        ref_clk = 1'h0;
        sys_rst = 1'h1;
        scramble = 1'h0;
        platSel = 4'h0;
        coreSel = 3'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        for (int i = 0; i < 16; i++)
        begin
            m = PLAT_TAB[i];
            h = CORE_TAB[i % 8];
            p = 32'(`REF_KHZ_RESET) * m;
            powerUp(4'(i), 3'(i));
            `CHECK("ratioLocked", ratioLocked, 1'h1)
            `CHECK("platformMult", platformMult, m)
            `CHECK("coreHalfRatio", coreHalfRatio, h)
            checkReg(`REG_REF_KHZ, 32'(`REF_KHZ_RESET), "refKhz");
            checkReg(`REG_LIMIT_CFG, 32'h0, "limitCfg");
            checkReg(`REG_PLAT_KHZ, p, "platKhz");
            checkReg(`REG_CORE_KHZ, p * h / 2, "coreKhz");
            checkReg(`REG_MEM_KHZ, p / 2, "memKhz");
            checkReg(`REG_STRAP_CODES, {23'h0, 1'h1, 1'h0, 3'(i), 4'(i)}, "strapCodes");
            checkReg(`REG_RANGE_FLAGS, {24'h0, expFlags(32'(`REF_KHZ_RESET), m, h, 2'h0,
                1'h0)}, "flags");
            `CHECK("ratioFault", ratioFault, |expFlags(`REF_KHZ_RESET, m, h, 2'h0, 1'h0))
        end
        powerUp(4'h4, 3'h4);
        axiWrite(`REG_REF_KHZ, 32'h000208D2, `RESP_OKAY);
        checkReg(`REG_REF_KHZ, 32'h000208D2, "refKhz");
        for (int g = 0; g < 8; g++)
        begin
            axiWrite(`REG_LIMIT_CFG, 32'(g), `RESP_OKAY);
            checkReg(`REG_LIMIT_CFG, 32'(g), "limitCfg");
            checkReg(`REG_RANGE_FLAGS, {24'h0, expFlags(32'h000208D2, 5'h04, 4'h4, 2'(g),
                g[2])}, "flags");
        end
        axiWrite(`REG_RATIOS, 32'hFFFFFFFF, `RESP_OKAY);
        checkReg(`REG_RATIOS, {20'h0, 4'h4, 3'h0, 5'h04}, "ratios");
        axiWrite(8'h20, 32'h0, `RESP_SLVERR);
        axiRead(8'h20);
        `CHECK("unmappedData", rd, 32'h0)
        `CHECK("unmappedResp", rr, `RESP_SLVERR)
        scramble <= 1'h1;
        repeat (20) @(posedge ref_clk);
        `CHECK("platformMult", platformMult, 5'h04)
        `CHECK("coreHalfRatio", coreHalfRatio, 4'h4)
        checkReg(`REG_STRAP_CODES, {23'h0, 1'h1, 1'h0, 3'h4, 4'h4}, "strapCodes");
        end_sim();
    end

    initial
    begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        end_sim();
    end
endmodule

bind pll_ratio_strap_config pll_ratio_properties chk (.ref_clk, .sys_rst, .platformRatioStrap,
    .coreRatioStrapBit2, .coreRatioStrapBit1, .coreRatioStrapBit0, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .platformMult, .coreHalfRatio, .ratioLocked,
    .ratioFault);
